// [hdl/adcpp_port.sv]
// Conversion control and parallel host port
// Functional notes
// R01 - Word select high: 12-bit words on data lines 0 to 11.
// R02 - Word select low: bytes on lines 0-7, line 8 is high-byte enable.
// R03 - Byte mode, enable low: low eight bits on lines 0 to 7.
// R04 - Byte mode, enable high: upper four bits on lines 0 to 3.
// R05 - High-byte read carries two-bit channel ID on bits 4 and 5.
// R06 - High-byte read drives bits 6 and 7 to zero.
// R07 - Host writes zeros to bits 4 to 7 of the high byte.
// R08 - Busy rises after start falling edge, stays high through conversion.
// R09 - Busy falls only after the result is in the output register.
// R10 - Track resumes on thirteenth master clock rising edge, before busy falls.
// R11 - Conversion lasts thirteen master clock cycles plus fixed extra delay.
// R12 - Master clock may be continuous or burst; both convert correctly.
// R13 - Start falling edge puts track-and-hold in hold, starts conversion.
// R14 - Start rising edge wakes device from auto power-down.
// R15 - Write strobe with chip select loads the control register.
// R16 - Read falling edge with chip select drives result on the bus.
// R17 - Data lines are bidirectional three-state under select and strobes.
// R18 - Lines 9 to 11 used only in word mode.
// R19 - Host holds chip select for every strobe.
// R20 - Lines released and strobes ignored without chip select or read.
// R21 - Byte mode needs two transfers per word, low then high.
`include "adcpp_map.svh"
module adcpp_port
   import adcpp_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       master_clock_in,
   input  wire logic                       conversion_start_n,
   input  wire logic                       chip_select_n,
   input  wire logic                       read_n,
   input  wire logic                       write_n,
   input  wire logic                       word_select,
   input  wire logic [`ADCPP_DATA_W-1:0]   data_in,
   output logic      [`ADCPP_DATA_W-1:0]   data_out,
   output logic      [`ADCPP_DATA_W-1:0]   data_oe,
   output logic                            busy,
   output logic                            track_hold,
   output logic                            powered_up,
   output logic      [`ADCPP_CTRL_W-1:0]   control_word,
   input  wire logic [`ADCPP_DATA_W-1:0]   sample_code,
   input  wire logic [`ADCPP_CHID_W-1:0]   sample_channel,
   input  wire logic [1:0]                 power_mode,
   output logic                            result_valid,
   input  wire logic                       result_ready,
   output logic      [`ADCPP_FIFO_W-1:0]   result_data
);
   localparam int NS = 8;
   // Two-flop synchronisers for every pin input
   logic [NS-1:0] s1_q, s2_q, s3_q;
   logic [NS-1:0] pin_raw;
   logic [`ADCPP_DATA_W-1:0] din1_q, din2_q;
   assign pin_raw = {master_clock_in, conversion_start_n, chip_select_n, read_n, write_n,
                     word_select, data_in[8], 1'b0};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q   <= 8'h7c;
         s2_q   <= 8'h7c;
         s3_q   <= 8'h7c;
         din1_q <= 12'h000;
         din2_q <= 12'h000;
      end else begin
         s1_q   <= pin_raw;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         din1_q <= data_in;
         din2_q <= din1_q;
      end
   end

   logic mclk_s, cst_s, cs_s, rd_s, wr_s, wsel_s, high_byte_enable_s;
   logic mclk_rise, cst_fall, cst_rise, rd_fall, wr_rise;
   assign mclk_s    = s2_q[7];
   assign cst_s     = s2_q[6];
   assign cs_s      = s2_q[5];
   assign rd_s      = s2_q[4];
   assign wr_s      = s2_q[3];
   assign wsel_s    = s2_q[2];
   // R02 byte-mode enable
   assign high_byte_enable_s    = ~wsel_s & s2_q[1];
   // R12 edge-driven, burst safe
   assign mclk_rise = s2_q[7] & ~s3_q[7];
   assign cst_fall  = ~s2_q[6] & s3_q[6];
   assign cst_rise  = s2_q[6] & ~s3_q[6];
   assign rd_fall   = ~s2_q[4] & s3_q[4];
   assign wr_rise   = s2_q[3] & ~s3_q[3];

   // Conversion sequencer
   adcpp_conv_t st_q, st_d;
   logic [3:0]  edge_q, edge_d;
   logic [3:0]  ext_q, ext_d;
   logic        busy_q, busy_d, hold_q, hold_d, pwr_q, pwr_d;
   logic [`ADCPP_DATA_W-1:0] res_q, res_d;
   logic [`ADCPP_CHID_W-1:0] rid_q, rid_d;
   logic        push;
   logic        fifo_ready;

   always_comb begin
      st_d   = st_q;
      edge_d = edge_q;
      ext_d  = ext_q;
      busy_d = busy_q;
      hold_d = hold_q;
      pwr_d  = pwr_q;
      res_d  = res_q;
      rid_d  = rid_q;
      push   = 1'b0;
      case (st_q)
         ADCPP_IDLE: begin
            // R13 hold and start
            if (cst_fall && pwr_q) begin
               st_d   = ADCPP_CONV;
               hold_d = 1'b1;
               // R08 busy rises
               busy_d = 1'b1;
               edge_d = 4'h0;
            end
         end
         ADCPP_CONV: begin
            // R11 thirteen clock edges
            if (mclk_rise) begin
               edge_d = edge_q + 4'h1;
               if (edge_q == 4'(`ADCPP_CONV_EDGES - 1)) begin
                  // R10 back to track
                  hold_d = 1'b0;
                  ext_d  = 4'h0;
                  st_d   = ADCPP_EXTRA;
               end
            end
         end
         ADCPP_EXTRA: begin
            // R11 fixed extra delay
            ext_d = ext_q + 4'h1;
            if (ext_q == 4'(`ADCPP_EXTRA_CYC - 1)) begin
               st_d = ADCPP_LOAD;
            end
         end
         ADCPP_LOAD: begin
            // Waits on the FIFO so no result is dropped
            if (fifo_ready) begin
               res_d  = sample_code;
               rid_d  = sample_channel;
               push   = 1'b1;
               // R09 busy falls after load
               busy_d = 1'b0;
               if (power_mode == `ADCPP_PWR_AUTO) begin
                  pwr_d = 1'b0;
               end
               st_d = ADCPP_IDLE;
            end
         end
         default: st_d = ADCPP_IDLE;
      endcase
      // R14 wake on start rising, wins over sleep
      if (cst_rise && power_mode == `ADCPP_PWR_AUTO) begin
         pwr_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= ADCPP_IDLE;
         edge_q <= 4'h0;
         ext_q  <= 4'h0;
         busy_q <= 1'b0;
         hold_q <= 1'b0;
         pwr_q  <= 1'b1;
         res_q  <= 12'h000;
         rid_q  <= 2'h0;
      end else begin
         st_q   <= st_d;
         edge_q <= edge_d;
         ext_q  <= ext_d;
         busy_q <= busy_d;
         hold_q <= hold_d;
         pwr_q  <= pwr_d;
         res_q  <= res_d;
         rid_q  <= rid_d;
      end
   end

   // Host bus
   logic [`ADCPP_CTRL_W-1:0] ctl_q, ctl_d;
   logic [`ADCPP_DATA_W-1:0] dout_q, dout_d, doe_q, doe_d;
   logic                     rd_act;
   assign rd_act = ~cs_s & ~rd_s;

   always_comb begin
      ctl_d  = ctl_q;
      dout_d = dout_q;
      doe_d  = 12'h000;
      // R15 write capture
      if (wr_rise && !cs_s) begin
         if (wsel_s) begin
            // R01 full word write
            ctl_d = din2_q;
         end else if (high_byte_enable_s) begin
            // R04 upper four bits, R07 host zeros ignored
            ctl_d[11:8] = din2_q[3:0];
         end else begin
            // R03 low byte
            ctl_d[7:0] = din2_q[7:0];
         end
      end
      // R16 result on bus
      if (rd_act) begin
         if (rd_fall) begin
            if (wsel_s) begin
               dout_d = res_q;
            end else if (high_byte_enable_s) begin
               // R05 channel ID, R06 top zeros
               dout_d = {4'h0, 2'h0, rid_q, res_q[11:8]};
            end else begin
               dout_d = {4'h0, res_q[7:0]};
            end
         end
         // R17 R18 drive only used lanes
         doe_d = wsel_s ? 12'hfff : 12'h0ff;
      end
      // R20 released otherwise
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q  <= `ADCPP_CTRL_RST;
         dout_q <= 12'h000;
         doe_q  <= 12'h000;
      end else begin
         ctl_q  <= ctl_d;
         dout_q <= dout_d;
         doe_q  <= doe_d;
      end
   end

   logic fv;
   logic [`ADCPP_FIFO_W-1:0] fd;
   logic [`ADCPP_FIFO_W-1:0] rdat_q;
   logic                     rval_q;
   logic                     take;
   assign take = fv & (~rval_q | result_ready);

   adcpp_fifo #(
      .WIDTH (`ADCPP_FIFO_W),
      .DEPTH (`ADCPP_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   ({sample_channel, sample_code}),
      .out_valid (fv),
      .out_ready (take),
      .out_data  (fd)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rval_q <= 1'b0;
         rdat_q <= 14'h0000;
      end else begin
         if (take) begin
            rval_q <= 1'b1;
            rdat_q <= fd;
         end else if (result_ready) begin
            rval_q <= 1'b0;
         end
      end
   end

   assign data_out     = dout_q;
   assign data_oe      = doe_q;
   assign busy         = busy_q;
   assign track_hold   = hold_q;
   assign powered_up   = pwr_q;
   assign control_word = ctl_q;
   assign result_valid = rval_q;
   assign result_data  = rdat_q;

   busy_start_a: assert property (@(posedge clk) disable iff (!rst_n) // R08
      (st_q == ADCPP_IDLE && cst_fall && pwr_q) |=> busy_q && hold_q)
      else $error("busy did not rise on start");
   sequence conv_done_s;
      st_q == ADCPP_LOAD && fifo_ready;
   endsequence
   busy_fall_a: assert property (@(posedge clk) disable iff (!rst_n) // R09
      $fell(busy_q) |-> $past(st_q) == ADCPP_LOAD && $past(fifo_ready))
      else $error("busy fell before load");
   load_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R09
      conv_done_s |=> !busy_q && st_q == ADCPP_IDLE)
      else $error("load did not end conversion");
   track_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
      $fell(hold_q) |-> $past(edge_q) == 4'(`ADCPP_CONV_EDGES - 1) && busy_q)
      else $error("track resumed on wrong edge");
   wake_start_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
      (cst_rise && power_mode == `ADCPP_PWR_AUTO) |=> pwr_q)
      else $error("no wake on start rise");
   word_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (wr_rise && !cs_s && wsel_s) |=> ctl_q == $past(din2_q))
      else $error("word write not captured");
   hi_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R05
      (rd_act && rd_fall && high_byte_enable_s) |=> dout_q[7:4] == {2'h0, $past(rid_q)})
      else $error("high byte id wrong");
   release_bus_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
      !$past(rd_act) |-> doe_q == 12'h000)
      else $error("bus driven without read");
   byte_lanes_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
      ($past(rd_act) && !$past(wsel_s)) |-> doe_q[11:8] == 4'h0)
      else $error("upper lanes driven in byte mode");
endmodule

// [hdl/adcpp_map.svh]
// Offsets-free constant map: field positions, widths and timing counts
`ifndef ADCPP_MAP_SVH
`define ADCPP_MAP_SVH
`define ADCPP_DATA_W        12
`define ADCPP_CTRL_W        12
`define ADCPP_CHID_W        2
`define ADCPP_CONV_EDGES    13
`define ADCPP_EXTRA_NS      100
`define ADCPP_CLK_NS        100
`define ADCPP_EXTRA_CYC     ((`ADCPP_EXTRA_NS + `ADCPP_CLK_NS - 1) / `ADCPP_CLK_NS)
`define ADCPP_FIFO_DEPTH    32
`define ADCPP_FIFO_W        14
`define ADCPP_CTRL_RST      12'h000
`define ADCPP_ID_LO         4
`define ADCPP_ID_HI         5
`define ADCPP_PWR_AUTO      2'h1
`endif

// [hdl/adcpp_pkg.sv]
// Types of the conversion port
`include "adcpp_map.svh"
package adcpp_pkg;
   typedef enum logic [1:0] {
      ADCPP_IDLE,
      ADCPP_CONV,
      ADCPP_EXTRA,
      ADCPP_LOAD
   } adcpp_conv_t;
   typedef logic [`ADCPP_DATA_W-1:0] adcpp_word_t;
endpackage

// [hdl/adcpp_fifo.sv]
// Parameterised valid/ready FIFO of flip-flops
module adcpp_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wp_d  = push ? wp_q + 1'b1 : wp_q;
      rp_d  = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_mem
         always_ff @(posedge clk) begin
            if (push && wp_q == AW'(i)) begin
               mem_q[i] <= in_data;
            end
         end
      end
   endgenerate
endmodule

// [verification/adcpp_host_model.sv]
// Master clock source on the host side, continuous or burst
module adcpp_host_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic burst,
   input  wire logic busy,
   output logic      mclk
);
   logic [2:0] div_q;
   logic [2:0] div_d;
   logic       run;
   // continuous or burst clock
   // Burst restarts the divider so the first high phase is full length
   assign run = !burst || busy;
   always_comb begin
      div_d = run ? div_q + 3'h1 : 3'h0;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_d;
      end
   end
   // Idle level low between bursts; high and low phases four cycles each
   assign mclk = run && div_q[2];
endmodule

// [verification/tb_top.sv]
// Self-checking bench of the conversion port
module tb_top;
   import adcpp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic ws; logic hb; logic bst; logic [11:0] code; logic [1:0] ch;} adcpp_row_t;
   logic        clk, rst_n, start_n, cs_n, rd_n, wr_n, ws, busy, th, pw, burst, mclk;
   logic        rvalid, rready;
   logic [11:0] dout, doe, din, host_d, ctl, code;
   logic [13:0] rdata;
   logic [1:0]  ch, pmode;
   logic        mclk_p;
   int          error_cnt, num_checks, n, rises;
   adcpp_row_t  rows [6];
   assign din = (doe & dout) | (~doe & host_d);
   adcpp_port dut (.clk(clk), .rst_n(rst_n), .master_clock_in(mclk),
      .conversion_start_n(start_n), .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n),
      .word_select(ws), .data_in(din), .data_out(dout), .data_oe(doe), .busy(busy),
      .track_hold(th), .powered_up(pw), .control_word(ctl), .sample_code(code),
      .sample_channel(ch), .power_mode(pmode), .result_valid(rvalid),
      .result_ready(rready), .result_data(rdata));
   adcpp_host_model host (.clk(clk), .rst_n(rst_n), .burst(burst), .busy(busy), .mclk(mclk));
   // Master clock rises seen while holding, cleared when idle
   always @(negedge clk) begin
      mclk_p <= mclk;
      if (!busy) begin
         rises <= 0;
      end else if (th && mclk && !mclk_p) begin
         rises <= rises + 1;
      end
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for a level on busy, th or result_valid
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      n = 0;
      while (sig !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (sig !== lvl) begin
         error_cnt++;
         $display("[ERR] wait expected %b seen %b", lvl, sig);
         report_and_stop();
      end
   endtask
   task automatic convert();
      @(negedge clk);
      start_n = 1'b0;
      wait_for(busy, 1'b1, 10);
      chk("hold", 14'h1, {13'h0, th});
      start_n = 1'b1;
      wait_for(th, 1'b0, 300);
      // track resumes while busy still high
      chk("busy_at_track", 14'h1, {13'h0, busy});
      // Burst clock starts with busy, so every rise is seen
      if (burst) begin
         chk("mclk_rises", 14'hd, 14'(rises));
      end
      wait_for(busy, 1'b0, 10);
   endtask
   task automatic bus_read(logic w, logic h, logic [11:0] exp, logic [11:0] eoe);
      @(negedge clk);
      ws = w;
      host_d = {3'h0, h, 8'h00};
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (5) @(negedge clk);
      chk("oe", {2'h0, eoe}, {2'h0, doe});
      chk("data", {2'h0, exp}, {2'h0, dout & doe});
      rd_n = 1'b1;
      cs_n = 1'b1;
      repeat (5) @(negedge clk);
      chk("released", 14'h0, {2'h0, doe});
   endtask
   task automatic bus_write(logic w, logic [11:0] v);
      @(negedge clk);
      ws = w;
      host_d = v;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      wr_n = 1'b1;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      @(negedge clk);
   endtask
   initial begin
      {start_n, cs_n, rd_n, wr_n, ws} = 5'h1f;
      rst_n = 1'b0;
      burst = 1'b0;
      rready = 1'b0;
      pmode = 2'h0;
      host_d = 12'h000;
      code = 12'h000;
      ch = 2'h0;
      error_cnt = 0;
      num_checks = 0;
      rows = '{'{1, 0, 0, 12'ha5c, 2'h0}, '{0, 0, 0, 12'h3b7, 2'h1}, '{0, 1, 0, 12'hc18, 2'h2},
               '{1, 0, 1, 12'hfff, 2'h3}, '{0, 0, 1, 12'h000, 2'h3}, '{0, 1, 1, 12'h9e4, 2'h3}};
      repeat (16) @(negedge clk);
      // Reset values
      chk("reset_oe", 14'h0, {2'h0, doe});
      chk("reset", 14'h1, {10'h0, busy, th, rvalid, pw});
      chk("ctl_reset", 14'h0, {2'h0, ctl});
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      $display("reset done");
      foreach (rows[i]) begin
         burst = rows[i].bst;
         code = rows[i].code;
         ch = rows[i].ch;
         convert();
         wait_for(rvalid, 1'b1, 10);
         chk("stream", {ch, code}, rdata);
         rready = 1'b1;
         @(negedge clk);
         rready = 1'b0;
         if (rows[i].ws) begin
            bus_read(1'b1, 1'b0, code, 12'hfff);
         end else if (!rows[i].hb) begin
            bus_read(1'b0, 1'b0, {4'h0, code[7:0]}, 12'h0ff);
         end else begin
            bus_read(1'b0, 1'b1, {4'h0, 2'h0, ch, code[11:8]}, 12'h0ff);
         end
         $display("row %0d done", i);
      end
      // Strobe without chip select drives nothing
      @(negedge clk);
      rd_n = 1'b0;
      repeat (5) @(negedge clk);
      chk("no_cs", 14'h0, {2'h0, doe});
      rd_n = 1'b1;
      $display("no select done");
      // Word write, then byte low and high halves
      bus_write(1'b1, 12'h5a3);
      chk("ctl_word", 14'h5a3, {2'h0, ctl});
      bus_write(1'b0, 12'h0c6);
      // host keeps bits 4 to 7 zero, line 8 high selects upper half
      bus_write(1'b0, 12'h109);
      chk("ctl_bytes", 14'h9c6, {2'h0, ctl});
      $display("write done");
      // Write without chip select is ignored
      @(negedge clk);
      ws = 1'b1;
      host_d = 12'h111;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      wr_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("ctl_no_cs", 14'h9c6, {2'h0, ctl});
      $display("ignored write done");
      // Reset in mid-conversion aborts it and restores defaults
      @(negedge clk);
      start_n = 1'b0;
      wait_for(busy, 1'b1, 10);
      rst_n = 1'b0;
      @(negedge clk);
      chk("mid_reset", 14'h1, {10'h0, busy, th, rvalid, pw});
      chk("ctl_mid_reset", 14'h0, {2'h0, ctl});
      start_n = 1'b1;
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      $display("mid reset done");
      // Auto power-down: asleep after a conversion, start refused until a rising edge
      pmode = 2'h1;
      code = 12'h6d2;
      ch = 2'h1;
      convert();
      chk("asleep", 14'h0, {13'h0, pw});
      wait_for(rvalid, 1'b1, 10);
      chk("auto_stream", 14'h16d2, rdata);
      start_n = 1'b0;
      repeat (6) @(negedge clk);
      chk("asleep_refused", 14'h0, {13'h0, busy});
      start_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("woken", 14'h1, {13'h0, pw});
      convert();
      $display("power down done");
      report_and_stop();
   end
endmodule
